// file: mcr_mode_regs.sv
/*
 * measurement and accumulation mode registers with the selection logic
 * they steer: line period source, peak phases and window, and the
 * per-phase energy increments fed to the accumulators.
 * assumes all datapath inputs and the register port are synchronous
 * to sys_clk; the serial host front end decodes into the register port.
 */
`timescale 1ns/10ps
`include "mcr_consts.svh"

module mcr_mode_regs
   import mcr_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic                  sys_clk,
   input  wire logic                  rst_n,
   input  wire logic [15:0]           reg_addr,
   input  wire logic                  reg_wr,
   input  wire logic [7:0]            reg_wdata,
   output      logic [7:0]            reg_rdata,
   input  wire logic                  zc_a,
   input  wire logic                  zc_b,
   input  wire logic                  zc_c,
   input  wire logic [7:0]            peak_window_cycles,
   input  wire logic signed [W-1:0]   va,
   input  wire logic signed [W-1:0]   vb,
   input  wire logic signed [W-1:0]   vc,
   input  wire logic signed [W-1:0]   ia,
   input  wire logic signed [W-1:0]   ib,
   input  wire logic signed [W-1:0]   ic,
   input  wire logic signed [W-1:0]   ia_shift,
   input  wire logic signed [W-1:0]   ib_shift,
   input  wire logic signed [W-1:0]   ic_shift,
   input  wire logic [W-1:0]          vrms_a,
   input  wire logic [W-1:0]          vrms_b,
   input  wire logic [W-1:0]          vrms_c,
   input  wire logic [W-1:0]          irms_a,
   input  wire logic [W-1:0]          irms_b,
   input  wire logic [W-1:0]          irms_c,
   output      logic                  line_period_zc,
   output      logic [2:0]            peak_phase_select,
   output      logic                  peak_window_done,
   output      logic signed [2*W+2:0] act_a,
   output      logic signed [2*W+2:0] act_b,
   output      logic signed [2*W+2:0] act_c,
   output      logic signed [2*W+2:0] react_a,
   output      logic signed [2*W+2:0] react_b,
   output      logic signed [2*W+2:0] react_c,
   output      logic [2*W-1:0]        appar_a,
   output      logic [2*W-1:0]        appar_b,
   output      logic [2*W-1:0]        appar_c
);

   localparam int AW = 2 * W + 3;

   localparam int PW = 2 * W;

   // refuse widths the product and increment sizing cannot serve
   if (W < 2 || W > 30) begin : g_w_check
      $error("mcr_mode_regs: W out of range");
   end

   // ==========================================================
   // registers
   logic [`MCR_MEAS_USED_BITS-1:0]  meas_mode;
   logic [`MCR_ACCUM_USED_BITS-1:0] accum_mode;
   logic [7:0]                      peak_cnt;

   wire wr_meas  = reg_wr && (reg_addr == `MCR_MEAS_MODE_ADDR);
   wire wr_accum = reg_wr && (reg_addr == `MCR_ACCUM_MODE_ADDR);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meas_mode  <= `MCR_MEAS_USED_BITS'(`MCR_MEAS_MODE_RST);
         accum_mode <= `MCR_ACCUM_USED_BITS'(`MCR_ACCUM_MODE_RST);
      end else begin
         if (wr_meas)
            meas_mode <= reg_wdata[`MCR_MEAS_USED_BITS-1:0];
         if (wr_accum)
            accum_mode <= reg_wdata[`MCR_ACCUM_USED_BITS-1:0];
      end
   end

   wire logic [7:0] next_rdata =
      (reg_addr == `MCR_MEAS_MODE_ADDR)  ? {3'h0, meas_mode}  :
      (reg_addr == `MCR_ACCUM_MODE_ADDR) ? {2'h0, accum_mode} : 8'h00;

   // ==========================================================
   // field decode
   wire mcr_phase_e      lp_sel = mcr_phase_e'(meas_mode[`MCR_LP_SEL_LSB +: 2]);
   wire logic [2:0]      peak_en = meas_mode[`MCR_PEAK_LSB +: 3];
   wire mcr_act_mode_e   act_md = mcr_act_mode_e'(accum_mode[`MCR_ACT_LSB +: 2]);
   wire mcr_react_mode_e rct_md = mcr_react_mode_e'(accum_mode[`MCR_REACT_LSB +: 2]);
   wire mcr_wire_e       wire_md = mcr_wire_e'(accum_mode[`MCR_WIRE_LSB +: 2]);

   wire logic next_lp_zc = (lp_sel == MCR_PHASE_B) ? zc_b :
                           (lp_sel == MCR_PHASE_C) ? zc_c : zc_a;

   // ==========================================================
   // peak window: crossings of every selected phase count
   wire logic [1:0] zc_hits = 2'(peak_en[0] & zc_a) + 2'(peak_en[1] & zc_b)
                            + 2'(peak_en[2] & zc_c);
   wire logic [8:0] cnt_sum = 9'(peak_cnt) + 9'(zc_hits);
   wire logic       win_hit = (peak_window_cycles != 8'h00)
                           && (cnt_sum >= 9'(peak_window_cycles));

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         peak_cnt <= 8'h00;
      else
         peak_cnt <= win_hit ? 8'h00 : cnt_sum[7:0];
   end

   // ==========================================================
   // wiring: effective phase B voltage
   wire logic signed [W+1:0] va_x = (W+2)'(va);
   wire logic signed [W+1:0] vc_x = (W+2)'(vc);
   wire logic signed [W+1:0] vb_eff =
      (wire_md == MCR_WIRE_4W_2SENS) ? -(va_x + vc_x) :
      (wire_md == MCR_WIRE_4W_DELTA) ? -va_x :
                                       (W+2)'(vb);
   wire logic b_off = (wire_md == MCR_WIRE_3W_DELTA);

   // ==========================================================
   // products
   wire logic signed [AW-1:0] pa = AW'(va * ia);
   wire logic signed [AW-1:0] pb = AW'(vb_eff * (W+2)'(ib));
   wire logic signed [AW-1:0] pc = AW'(vc * ic);
   wire logic signed [AW-1:0] qa = AW'(va * ia_shift);
   wire logic signed [AW-1:0] qb = AW'(vb_eff * (W+2)'(ib_shift));
   wire logic signed [AW-1:0] qc = AW'(vc * ic_shift);

   function automatic logic signed [AW-1:0] act_f(input logic signed [AW-1:0] p,
                                                  input mcr_act_mode_e m);
      if (m == MCR_ACT_ABS && p < 0)
         return -p;
      return p;
   endfunction : act_f

   function automatic logic signed [AW-1:0] rct_f(input logic signed [AW-1:0] q,
                                                  input logic signed [AW-1:0] p,
                                                  input mcr_react_mode_e m);
      if (m == MCR_REACT_BY_ACT_SIGN && p < 0)
         return -q;
      return q;
   endfunction : rct_f

   wire logic signed [AW-1:0] next_act_b   = b_off ? '0 : act_f(pb, act_md);
   wire logic signed [AW-1:0] next_react_b = b_off ? '0 : rct_f(qb, pb, rct_md);
   wire logic [2*W-1:0]       next_appar_b = b_off ? '0 : PW'(vrms_b) * PW'(irms_b);

   // ==========================================================
   // registered outputs
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata         <= 8'h00;
         line_period_zc    <= 1'b0;
         peak_phase_select <= 3'h0;
         peak_window_done  <= 1'b0;
         act_a             <= '0;
         act_b             <= '0;
         act_c             <= '0;
         react_a           <= '0;
         react_b           <= '0;
         react_c           <= '0;
         appar_a           <= '0;
         appar_b           <= '0;
         appar_c           <= '0;
      end else begin
         reg_rdata         <= next_rdata;
         line_period_zc    <= next_lp_zc;
         peak_phase_select <= peak_en;
         peak_window_done  <= win_hit;
         act_a             <= act_f(pa, act_md);
         act_b             <= next_act_b;
         act_c             <= act_f(pc, act_md);
         react_a           <= rct_f(qa, pa, rct_md);
         react_b           <= next_react_b;
         react_c           <= rct_f(qc, pc, rct_md);
         appar_a           <= PW'(vrms_a) * PW'(irms_a);
         appar_b           <= next_appar_b;
         appar_c           <= PW'(vrms_c) * PW'(irms_c);
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   property p_lp_sel_rsvd;
      (lp_sel == MCR_PHASE_RSVD) |=> (line_period_zc == $past(zc_a));
   endproperty
   a_lp_sel_rsvd: assert property (p_lp_sel_rsvd) else $error("code 11 not phase A");

   property p_peak_sel;
      wr_meas |-> ##2 (peak_phase_select == $past(reg_wdata[4:2], 2));
   endproperty
   a_peak_sel: assert property (p_peak_sel) else $error("peak select not written");

   property p_peak_all;
      (peak_en == 3'h7 && zc_a && zc_b && zc_c && peak_window_cycles == 8'h03
       && peak_cnt == 8'h00) |=> peak_window_done;
   endproperty
   a_peak_all: assert property (p_peak_all) else $error("window not shortened");

   property p_meas_rsvd;
      (reg_addr == `MCR_MEAS_MODE_ADDR) |=> (reg_rdata[7:5] == 3'h0);
   endproperty
   a_meas_rsvd: assert property (p_meas_rsvd) else $error("reserved bits not zero");

   property p_act_signed;
      (act_md != MCR_ACT_ABS) |=> (act_a == $past(pa));
   endproperty
   a_act_signed: assert property (p_act_signed) else $error("signed active wrong");

   property p_act_abs;
      (act_md == MCR_ACT_ABS && pc < 0) |=> (act_c == -$past(pc));
   endproperty
   a_act_abs: assert property (p_act_abs) else $error("magnitude active wrong");

   property p_react_neg;
      (rct_md == MCR_REACT_BY_ACT_SIGN && pa < 0) |=> (react_a == -$past(qa));
   endproperty
   a_react_neg: assert property (p_react_neg) else $error("reactive not negated");

   property p_react_signed;
      (rct_md != MCR_REACT_BY_ACT_SIGN) |=> (react_c == $past(qc));
   endproperty
   a_react_signed: assert property (p_react_signed) else $error("signed reactive wrong");

   sequence s_wire_delta3;
      wire_md == MCR_WIRE_3W_DELTA;
   endsequence
   property p_b_zero;
      s_wire_delta3 |=> (act_b == '0 && react_b == '0 && appar_b == '0);
   endproperty
   a_b_zero: assert property (p_b_zero) else $error("phase B not zeroed");

   property p_wire_2sens;
      (wire_md == MCR_WIRE_4W_2SENS && act_md != MCR_ACT_ABS)
         |=> (act_b == $past(-(AW'(va * ib) + AW'(vc * ib))));
   endproperty
   a_wire_2sens: assert property (p_wire_2sens) else $error("vb not -(va+vc)");

   property p_wire_delta4;
      (wire_md == MCR_WIRE_4W_DELTA && act_md != MCR_ACT_ABS)
         |=> (act_b == $past(-AW'(va * ib)));
   endproperty
   a_wire_delta4: assert property (p_wire_delta4) else $error("vb not -va");

endmodule : mcr_mode_regs

// file: mcr_consts.svh
/*
 * register offsets, field positions and reset values of the metering
 * mode configuration registers.
 * assumes inclusion by mcr_pkg users only; definitions only.
 */
`ifndef MCR_CONSTS_SVH
`define MCR_CONSTS_SVH

// ==========================================================
// offsets
`define MCR_MEAS_MODE_ADDR   16'he700
`define MCR_ACCUM_MODE_ADDR  16'he701

// ==========================================================
// measurement_mode fields
`define MCR_LP_SEL_LSB       0
`define MCR_PEAK_LSB         2
`define MCR_MEAS_USED_BITS   5
`define MCR_MEAS_MODE_RST    8'h1c

// ==========================================================
// accumulation_mode fields
`define MCR_ACT_LSB          0
`define MCR_REACT_LSB        2
`define MCR_WIRE_LSB         4
`define MCR_ACCUM_USED_BITS  6
`define MCR_ACCUM_MODE_RST   8'h00

`endif

// file: mcr_pkg.sv
/*
 * types of the metering mode configuration registers.
 * assumes nothing of its surroundings.
 */
package mcr_pkg;

   typedef enum logic [1:0] {
      MCR_PHASE_A,
      MCR_PHASE_B,
      MCR_PHASE_C,
      MCR_PHASE_RSVD
   } mcr_phase_e;

   typedef enum logic [1:0] {
      MCR_ACT_SIGNED,
      MCR_ACT_RSVD1,
      MCR_ACT_RSVD2,
      MCR_ACT_ABS
   } mcr_act_mode_e;

   typedef enum logic [1:0] {
      MCR_REACT_SIGNED,
      MCR_REACT_RSVD1,
      MCR_REACT_BY_ACT_SIGN,
      MCR_REACT_RSVD3
   } mcr_react_mode_e;

   typedef enum logic [1:0] {
      MCR_WIRE_4W_3SENS,
      MCR_WIRE_3W_DELTA,
      MCR_WIRE_4W_2SENS,
      MCR_WIRE_4W_DELTA
   } mcr_wire_e;

endpackage : mcr_pkg

// file: mcr_host_model.sv
/* host side of the register port: byte writes and reads.
   assumes the bench calls wr and rd from one process only. */
`timescale 1ns/10ps
module mcr_host_model (
   input  wire logic        sys_clk,
   output      logic [15:0] reg_addr,
   output      logic        reg_wr,
   output      logic [7:0]  reg_wdata,
   input  wire logic [7:0]  reg_rdata
);
   initial begin
      reg_addr  = 16'h0000;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
   end

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge sys_clk);
      reg_wr    = 1'b0;
      // released data no longer shows the last value
      reg_wdata = ~d;
   endtask : wr

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask : rd
endmodule : mcr_host_model

// file: tb_top.sv
/* bench of the mode registers: reset values, read-back, line period and
   peak selection, energy increments for every mode combination.
   assumes mcr_host_model drives the register port. */
`timescale 1ns/10ps
module tb_top;
   // ==========================================================
   // signals
   localparam int W  = 8;
   localparam int AW = 2*W+3;
   logic                 sys_clk, rst_n, reg_wr, zc_a, zc_b, zc_c;
   logic                 line_period_zc, peak_window_done;
   logic [15:0]          reg_addr;
   logic [7:0]           reg_wdata, reg_rdata, peak_window_cycles, lf, rd;
   logic [2:0]           peak_phase_select;
   logic signed [W-1:0]  va, vb, vc, ia, ib, ic, ia_shift, ib_shift, ic_shift;
   logic [W-1:0]         vrms_a, vrms_b, vrms_c, irms_a, irms_b, irms_c;
   logic signed [AW-1:0] act_a, act_b, act_c, react_a, react_b, react_c;
   logic [2*W-1:0]       appar_a, appar_b, appar_c;
   int                   error_cnt, checks, done_cnt;

   mcr_mode_regs #(.W(W)) mcr_mode_regs_i (.sys_clk, .rst_n, .reg_addr, .reg_wr,
      .reg_wdata, .reg_rdata, .zc_a, .zc_b, .zc_c, .peak_window_cycles, .va, .vb, .vc,
      .ia, .ib, .ic, .ia_shift, .ib_shift, .ic_shift, .vrms_a, .vrms_b, .vrms_c,
      .irms_a, .irms_b, .irms_c, .line_period_zc, .peak_phase_select, .peak_window_done,
      .act_a, .act_b, .act_c, .react_a, .react_b, .react_c, .appar_a, .appar_b, .appar_c);
   mcr_host_model mcr_host_model_i (.sys_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata);

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   always @(negedge sys_clk) begin
      if (peak_window_done === 1'b1) done_cnt++;
   end

   // ==========================================================
   // expectations and helpers
   function automatic logic [7:0] lfsr_next(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction : lfsr_next

   function automatic logic signed [AW-1:0] exp_act(input int p, input logic [1:0] m);
      return AW'((m == 2'h3 && p < 0) ? -p : p);
   endfunction : exp_act

   function automatic logic signed [AW-1:0] exp_react(input int q, input int p,
                                                      input logic [1:0] m);
      return AW'((m == 2'h2 && p < 0) ? -q : q);
   endfunction : exp_react

   task automatic chk(input logic [AW-1:0] got, input logic [AW-1:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim

   task automatic load_rand();
      logic [15*W-1:0] rv;
      for (int k = 0; k < 15; k++) begin
         lf = lfsr_next(lf);
         rv = {rv[14*W-1:0], lf};
      end
      {va, vb, vc, ia, ib, ic, ia_shift, ib_shift, ic_shift,
       vrms_a, vrms_b, vrms_c, irms_a, irms_b, irms_c} = rv;
   endtask : load_rand

   task automatic reset_chk();
      rst_n = 1'b0;
      repeat (12) @(negedge sys_clk);
      rst_n = 1'b1;
      mcr_host_model_i.rd(16'he700, rd);
      chk(rd, 8'h1c, "meas reset");
      mcr_host_model_i.rd(16'he701, rd);
      chk(rd, 8'h00, "accum reset");
      chk(peak_phase_select, 3'h7, "peak reset");
      mcr_host_model_i.rd(16'he7ff, rd);
      chk(rd, 8'h00, "unmapped read");
      $display("reset test done");
   endtask : reset_chk

   task automatic pulse_zc(input logic [2:0] z);
      @(negedge sys_clk);
      {zc_c, zc_b, zc_a} = z;
      @(negedge sys_clk);
      {zc_c, zc_b, zc_a} = 3'h0;
   endtask : pulse_zc

   task automatic chk_power(input logic [1:0] am, input logic [1:0] rm, input logic [1:0] wm);
      int vbe;
      int p_a;
      int p_b;
      int p_c;
      vbe = int'(vb);
      if (wm == 2'h2) vbe = -(int'(va) + int'(vc));
      if (wm == 2'h3) vbe = -int'(va);
      p_a = int'(va) * int'(ia);
      p_b = vbe * int'(ib);
      chk(act_a, exp_act(p_a, am), "act a");
      chk(react_a, exp_react(int'(va) * int'(ia_shift), p_a, rm), "react a");
      p_c = int'(vc) * int'(ic);
      chk(act_c, exp_act(p_c, am), "act c");
      chk(react_c, exp_react(int'(vc) * int'(ic_shift), p_c, rm), "react c");
      chk(appar_a, AW'(vrms_a) * AW'(irms_a), "appar a");
      chk(appar_c, AW'(vrms_c) * AW'(irms_c), "appar c");
      if (wm == 2'h1) begin
         chk(act_b, '0, "act b delta");
         chk(react_b, '0, "react b delta");
         chk(appar_b, '0, "appar b delta");
      end else begin
         chk(act_b, exp_act(p_b, am), "act b");
         chk(react_b, exp_react(vbe * int'(ib_shift), p_b, rm), "react b");
         chk(appar_b, AW'(vrms_b) * AW'(irms_b), "appar b");
      end
   endtask : chk_power

   // ==========================================================
   // sequence
   initial begin
      repeat (100000) @(posedge sys_clk);
      error_cnt++;
      end_sim();
   end

   initial begin
      {zc_c, zc_b, zc_a} = 3'h0;
      peak_window_cycles = 8'h03;
      lf = 8'h36;
      done_cnt = 0;
      load_rand();
      reset_chk();
      pulse_zc(3'h7);
      repeat (3) @(negedge sys_clk);
      chk(done_cnt, 1, "window all phases");
      mcr_host_model_i.wr(16'he700, 8'h04);
      @(negedge sys_clk);
      chk(peak_phase_select, 3'h1, "peak select a");
      done_cnt = 0;
      pulse_zc(3'h7);
      pulse_zc(3'h7);
      repeat (3) @(negedge sys_clk);
      chk(done_cnt, 0, "window a only early");
      pulse_zc(3'h7);
      repeat (3) @(negedge sys_clk);
      chk(done_cnt, 1, "window a only end");
      $display("peak test done");
      for (int c = 0; c < 4; c++) begin
         mcr_host_model_i.wr(16'he700, 8'he0 | 8'h1c | 8'(c));
         mcr_host_model_i.rd(16'he700, rd);
         chk(rd, 8'h1c | 8'(c), "meas readback");
         for (int p = 0; p < 3; p++) begin
            {zc_c, zc_b, zc_a} = 3'h1 << p;
            @(negedge sys_clk);
            chk(line_period_zc, p == c % 3, "line period");
            {zc_c, zc_b, zc_a} = 3'h0;
         end
      end
      $display("line period test done");
      for (int m = 0; m < 64; m++) begin
         mcr_host_model_i.wr(16'he701, 8'hc0 | 8'(m));
         mcr_host_model_i.rd(16'he701, rd);
         chk(rd, 8'(m), "accum readback");
         for (int k = 0; k < 3; k++) begin
            load_rand();
            @(negedge sys_clk);
            chk_power(2'(m), 2'(m >> 2), 2'(m >> 4));
         end
      end
      $display("energy test done");
      reset_chk();
      end_sim();
   end
endmodule : tb_top
